// ---- lcr_column_slave.v ----
// lcr_column_slave.v: two-wire slave, display ram and row scan of a column driver.
// assumes scl, sda and sync come from outside clk's domain; sda is open drain,
// resolved outside from sdaOe (sdaOut is always low).
//
// What this block does
// - device identity among cascaded drivers comes from four board id pins.
// - slave address low bit follows the address select pin.
// - reset gives blank, 1:32, bank 0, pointer 0,0, character mode, counter 0.
// - sync pulse from row driver steps the display row scan.
// - ram holds four banks of forty bytes.
// - display bytes stored or returned only when counter equals board id.
// - slave receiver and transmitter, deserialising and serialising bytes.
// - character, half-graphic and full-graphic orders for byte placement.
// - first location set by device select, load column and access bank bits.
// - counter advances device to device and wraps from 15 to 0.
// - rows scanned follow the multiplex rate bits.
// - show state bits and top bank are applied to the column outputs.
// - all matching devices acknowledge the address; others ignore the transfer.
// - in writes every addressed device acknowledges each command byte.
// - data bytes acknowledged only by the device whose id matches.
// - in reads the device transmits ram bytes after the address acknowledge.
// - after an unacknowledged read byte the device releases the data line.
// - pointer and counter advance after every display byte, read or written.
// - command top bit flags continuation; commands only in write transfers.
// - command decode: load column, set mode, device select, start bank, access.
// - set mode decodes multiplex rate and show state.
// - access mode 00 character, 01 half, 10 full; 11 is start bank.

`timescale 1ns/1ps
`include "lcr_defs.vh"

module lcr_column_slave #(
	parameter [5:0] SLAVE_ADDR_HI = 6'h2a, // arbitrary value
	parameter COLS = 40
) (
	input wire clk,
	input wire reset_n,
	input wire scl,
	input wire sdaIn,
	output wire sdaOut,
	output reg sdaOe,
	input wire sync,
	input wire addressSelectPin,
	input wire [3:0] boardIdPins,
	output reg [COLS-1:0] colOut,
	output reg [4:0] rowIndex,
	output reg [1:0] muxRate,
	output reg [1:0] showState,
	output reg systemType,
	output reg [1:0] topBank,
	output reg [1:0] accessOrder,
	output reg [1:0] bankPick,
	output reg [5:0] xPointer,
	output reg [3:0] subCounter,
	output reg cmdPhase
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_AACK = 3'h2;
	localparam [2:0] ST_RX = 3'h3;
	localparam [2:0] ST_RACK = 3'h4;
	localparam [2:0] ST_TX = 3'h5;
	localparam [2:0] ST_TACK = 3'h6;
	localparam [2:0] ST_WAIT = 3'h7;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function [7:0] ramIndex;
		input [1:0] bank;
		input [5:0] col;
		begin
			ramIndex = ({6'h00, bank} * `LCR_COLS) + {2'h0, col};
		end
	endfunction

	// returns {sub, bank, x} after one display byte
	function [11:0] nextPtr;
		input [1:0] mode;
		input [3:0] sub;
		input [1:0] bank;
		input [5:0] col;
		reg stepCol;
		begin
			stepCol = 1'b0;
			nextPtr = {sub, bank, col};
			case (mode)
				`LCR_ACC_HALF: begin
					nextPtr[7:6] = {bank[1], ~bank[0]};
					stepCol = bank[0];
				end
				`LCR_ACC_FULL: begin
					nextPtr[7:6] = bank + 2'h1;
					stepCol = (bank == 2'h3);
				end
				default: begin
					stepCol = 1'b1;
				end
			endcase
			if (stepCol) begin
				if (col == `LCR_X_LAST) begin
					nextPtr[5:0] = `LCR_RST_X;
					nextPtr[11:8] = sub + 4'h1;
				end else begin
					nextPtr[5:0] = col + 6'h01;
				end
			end
		end
	endfunction

	function [4:0] rowLast;
		input [1:0] mux;
		begin
			if (mux == `LCR_MUX_32) begin
				rowLast = `LCR_ROW_LAST_32;
			end else begin
				rowLast = {mux - 2'h1, 3'h7};
			end
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers and filter
	// ----------------------------------------
	// bit 0 scl, bit 1 sda, bit 2 sync
	reg [2:0] pinSt1;
	reg [2:0] pinSt2;
	reg [2:0] pinSt3;
	reg [2:0] pinF;
	reg [2:0] pinPrev;
	wire [2:0] pinAgree;

	assign pinAgree = ~(pinSt2 ^ pinSt3);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinSt1 <= `LCR_PIN_IDLE;
			pinSt2 <= `LCR_PIN_IDLE;
			pinSt3 <= `LCR_PIN_IDLE;
			pinF <= `LCR_PIN_IDLE;
			pinPrev <= `LCR_PIN_IDLE;
		end else begin
			pinSt1 <= {sync, sdaIn, scl};
			pinSt2 <= pinSt1;
			pinSt3 <= pinSt2;
			pinF <= (pinAgree & pinSt3) | (~pinAgree & pinF);
			pinPrev <= pinF;
		end
	end

	wire sclRise = pinF[0] & ~pinPrev[0];
	wire sclFall = ~pinF[0] & pinPrev[0];
	wire sdaBit = pinF[1];
	wire startCond = pinF[0] & pinPrev[0] & pinPrev[1] & ~pinF[1];
	wire stopCond = pinF[0] & pinPrev[0] & ~pinPrev[1] & pinF[1];
	wire syncRise = pinF[2] & ~pinPrev[2];

	// ----------------------------------------
	// display ram
	// ----------------------------------------
	reg [7:0] ram [0:`LCR_RAM_WORDS-1];
	reg [7:0] shiftReg;
	reg [7:0] txShift;
	reg [3:0] bitCnt;
	reg [2:0] state;
	reg readMode;
	reg txDrive;
	reg masterAck;

	wire idMatch = (subCounter == boardIdPins);
	wire [7:0] ptrIndex = ramIndex(bankPick, xPointer);
	wire [11:0] ptrNext = nextPtr(accessOrder, subCounter, bankPick, xPointer);
	wire byteEnd = sclFall & (bitCnt == `LCR_BYTE_DONE);
	wire dataWrite = (state == ST_RX) & byteEnd & ~cmdPhase & idMatch;

	always @(posedge clk) begin
		if (dataWrite) begin
			ram[ptrIndex] <= shiftReg;
		end
	end

	// ----------------------------------------
	// bus state machine
	// ----------------------------------------
	assign sdaOut = 1'b0;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			sdaOe <= 1'b0;
			bitCnt <= 4'h0;
			shiftReg <= 8'h00;
			txShift <= 8'h00;
			readMode <= 1'b0;
			txDrive <= 1'b0;
			masterAck <= 1'b0;
			cmdPhase <= 1'b1;
			muxRate <= `LCR_MUX_32;
			showState <= `LCR_SHOW_BLANK;
			systemType <= 1'b0;
			topBank <= `LCR_RST_BANK;
			accessOrder <= `LCR_ACC_CHAR;
			bankPick <= `LCR_RST_BANK;
			xPointer <= `LCR_RST_X;
			subCounter <= `LCR_RST_SUB;
		end else if (startCond) begin
			state <= ST_ADDR;
			bitCnt <= 4'h0;
			sdaOe <= 1'b0;
			cmdPhase <= 1'b1;
		end else if (stopCond) begin
			state <= ST_IDLE;
			sdaOe <= 1'b0;
		end else begin
			if (sclRise && state != ST_TACK && bitCnt != `LCR_BYTE_DONE) begin
				shiftReg <= {shiftReg[6:0], sdaBit};
				bitCnt <= bitCnt + 4'h1;
			end
			case (state)
				ST_ADDR: begin
					if (byteEnd) begin
						if (shiftReg[7:1] == {SLAVE_ADDR_HI, addressSelectPin}) begin
							readMode <= shiftReg[0];
							sdaOe <= 1'b1;
							state <= ST_AACK;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					if (sclFall) begin
						bitCnt <= 4'h0;
						if (readMode) begin
							txShift <= ram[ptrIndex];
							txDrive <= idMatch;
							sdaOe <= idMatch & ~ram[ptrIndex][7];
							{subCounter, bankPick, xPointer} <= ptrNext;
							state <= ST_TX;
						end else begin
							sdaOe <= 1'b0;
							state <= ST_RX;
						end
					end
				end
				ST_RX: begin
					if (byteEnd) begin
						state <= ST_RACK;
						if (cmdPhase) begin
							sdaOe <= 1'b1;
							cmdPhase <= shiftReg[`LCR_CONT_BIT];
							if (shiftReg[6] == `LCR_OP_LOADX) begin
								if (shiftReg[5:0] <= `LCR_X_LAST) begin
									xPointer <= shiftReg[5:0];
								end
							end else if (shiftReg[6:5] == `LCR_OP_MODE) begin
								systemType <= shiftReg[4];
								showState <= shiftReg[3:2];
								muxRate <= shiftReg[1:0];
							end else if (shiftReg[6:4] == `LCR_OP_DEVSEL) begin
								subCounter <= shiftReg[3:0];
							end else if (shiftReg[6:2] == `LCR_OP_BANK) begin
								topBank <= shiftReg[1:0];
							end else begin
								accessOrder <= shiftReg[3:2];
								bankPick <= shiftReg[1:0];
							end
						end else begin
							sdaOe <= idMatch;
							{subCounter, bankPick, xPointer} <= ptrNext;
						end
					end
				end
				ST_RACK: begin
					if (sclFall) begin
						sdaOe <= 1'b0;
						bitCnt <= 4'h0;
						state <= ST_RX;
					end
				end
				ST_TX: begin
					if (byteEnd) begin
						sdaOe <= 1'b0;
						state <= ST_TACK;
					end else if (sclFall) begin
						txShift <= {txShift[6:0], 1'b1};
						sdaOe <= txDrive & ~txShift[6];
					end
				end
				ST_TACK: begin
					if (sclRise) begin
						masterAck <= ~sdaBit;
						bitCnt <= `LCR_ACK_SAMPLED;
					end else if (sclFall && bitCnt == `LCR_ACK_SAMPLED) begin
						bitCnt <= 4'h0;
						if (masterAck) begin
							txShift <= ram[ptrIndex];
							txDrive <= idMatch;
							sdaOe <= idMatch & ~ram[ptrIndex][7];
							{subCounter, bankPick, xPointer} <= ptrNext;
							state <= ST_TX;
						end else begin
							sdaOe <= 1'b0;
							state <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					sdaOe <= 1'b0;
				end
				default: begin
					sdaOe <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// row scan and column outputs
	// ----------------------------------------
	wire [1:0] scanBank = topBank + rowIndex[4:3];
	integer c;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rowIndex <= 5'h00;
		end else if (syncRise) begin
			if (rowIndex >= rowLast(muxRate)) begin
				rowIndex <= 5'h00;
			end else begin
				rowIndex <= rowIndex + 5'h01;
			end
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			colOut <= {COLS{1'b0}};
		end else begin
			for (c = 0; c < COLS; c = c + 1) begin
				case (showState)
					`LCR_SHOW_NORMAL: begin
						colOut[c] <= ram[ramIndex(scanBank, c[5:0])][rowIndex[2:0]];
					end
					`LCR_SHOW_ALLON: begin
						colOut[c] <= 1'b1;
					end
					`LCR_SHOW_INVERSE: begin
						colOut[c] <= ~ram[ramIndex(scanBank, c[5:0])][rowIndex[2:0]];
					end
					default: begin
						colOut[c] <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule // lcr_column_slave

// ---- lcr_defs.vh ----
// lcr_defs.vh: named constants for the column driver slave.
// assumes inclusion by bare name from the design file.
`ifndef LCR_DEFS_VH
`define LCR_DEFS_VH

// ----------------------------------------
// display ram geometry
// ----------------------------------------
`define LCR_COLS 8'h28
`define LCR_X_LAST 6'h27
`define LCR_RAM_WORDS 160
`define LCR_ROW_LAST_32 5'h1f

// ----------------------------------------
// command byte fields
// ----------------------------------------
`define LCR_CONT_BIT 7
`define LCR_OP_LOADX 1'h0
`define LCR_OP_MODE 2'h2
`define LCR_OP_DEVSEL 3'h6
`define LCR_OP_BANK 5'h1f
`define LCR_OP_ACCESS 3'h7

// ----------------------------------------
// access modes, multiplex rates, show states
// ----------------------------------------
`define LCR_ACC_CHAR 2'h0
`define LCR_ACC_HALF 2'h1
`define LCR_ACC_FULL 2'h2
`define LCR_MUX_32 2'h0
`define LCR_SHOW_BLANK 2'h0
`define LCR_SHOW_NORMAL 2'h1
`define LCR_SHOW_ALLON 2'h2
`define LCR_SHOW_INVERSE 2'h3

// ----------------------------------------
// bus bit counting and reset values
// ----------------------------------------
`define LCR_BYTE_DONE 4'h8
`define LCR_ACK_SAMPLED 4'h9
`define LCR_PIN_IDLE 3'h3
`define LCR_RST_BANK 2'h0
`define LCR_RST_X 6'h00
`define LCR_RST_SUB 4'h0

`endif

// ---- lcr_column_slave_props.sv ----
// lcr_column_slave_props.sv: port assertions for the column driver slave.
// assumes it is bound into every lcr_column_slave instance.
`timescale 1ns/1ps
module lcr_column_slave_props #(
	parameter COLS = 40
) (
	input wire clk,
	input wire reset_n,
	input wire sdaOut,
	input wire scl,
	input wire sdaOe,
	input wire [COLS-1:0] colOut,
	input wire [4:0] rowIndex,
	input wire [1:0] muxRate,
	input wire [1:0] showState,
	input wire [1:0] topBank,
	input wire [1:0] accessOrder,
	input wire [1:0] bankPick,
	input wire [5:0] xPointer,
	input wire [3:0] subCounter,
	input wire cmdPhase
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// ------
	// properties
	// ------
	property p_reset; !$past(reset_n) |-> cmdPhase && !{showState, muxRate, topBank,
		accessOrder, bankPick, xPointer, subCounter}; endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	property p_drive; sdaOut == 1'b0; endproperty
	a_drive: assert property (p_drive) else $error("data pin value not low");
	property p_sdastable; $changed(sdaOe) |-> !scl; endproperty
	a_sdastable: assert property (p_sdastable) else $error("data pin moved while clock high");
	property p_mode; $changed({muxRate, showState, topBank, accessOrder}) |-> $past(cmdPhase);
	endproperty
	a_mode: assert property (p_mode) else $error("setting changed by data");
	property p_xrange; xPointer <= 6'h27; endproperty
	a_xrange: assert property (p_xrange) else $error("column out of range");
	property p_xstep; !$past(cmdPhase) && accessOrder == 2'h0 && $changed(xPointer) |->
		xPointer == ($past(xPointer) == 6'h27 ? 6'h00 : $past(xPointer) + 6'h01); endproperty
	a_xstep: assert property (p_xstep) else $error("column step wrong");
	property p_sub; $changed(subCounter) |-> $past(cmdPhase) ||
		subCounter == $past(subCounter) + 4'h1; endproperty
	a_sub: assert property (p_sub) else $error("counter step wrong");
	property p_row; $changed(rowIndex) |-> rowIndex == 5'h00 ||
		rowIndex == $past(rowIndex) + 5'h01; endproperty
	a_row: assert property (p_row) else $error("row step wrong");
	property p_allon; showState == 2'h2 && $past(showState) == 2'h2 |-> &colOut; endproperty
	a_allon: assert property (p_allon) else $error("all on not shown");
	c_data: cover property (!cmdPhase && $changed(xPointer));
	c_wrap: cover property ($changed(rowIndex) && rowIndex == 5'h00);
	c_allon: cover property (showState == 2'h2);
endmodule // lcr_column_slave_props
bind lcr_column_slave lcr_column_slave_props #(.COLS(COLS)) u_lcr_column_slave_props (.clk,
	.reset_n, .sdaOut, .scl, .sdaOe, .colOut, .rowIndex, .muxRate, .showState, .topBank,
	.accessOrder,
	.bankPick, .xPointer, .subCounter, .cmdPhase);

// ---- lcr_bus_master.sv ----
// lcr_bus_master.sv: behavioural two-wire master for the slave bench.
// assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module lcr_bus_master (
	input wire clk,
	input wire sdaWire,
	output reg scl = 1'b1,
	output reg sdaOe = 1'b0,
	output reg rxValid = 1'b0,
	output reg [8:0] rxWord = 9'h000
);
	reg r;
	reg [7:0] v;
	integer k;
	// quarter of the 320 ns bus period
	task q;
		repeat (2) @(posedge clk);
	endtask
	// long low, short high: slave answers about five clocks after scl falls
	task bitx(input b);
		@(posedge clk);
		sdaOe <= !b;
		repeat (5) @(posedge clk);
		scl <= 1'b1;
		q;
		r = sdaWire;
		scl <= 1'b0;
	endtask
	task post(input [8:0] w);
		rxWord <= w;
		rxValid <= 1'b1;
		@(posedge clk);
		rxValid <= 1'b0;
	endtask
	task start;
		q;
		q;
		sdaOe <= 1'b0;
		q;
		scl <= 1'b1;
		q;
		sdaOe <= 1'b1;
		q;
		scl <= 1'b0;
	endtask
	task stop;
		q;
		sdaOe <= 1'b1;
		q;
		q;
		scl <= 1'b1;
		q;
		sdaOe <= 1'b0;
		q;
	endtask
	task wbyte(input [7:0] d);
		for (k = 7; k >= 0; k--) bitx(d[k]);
		bitx(1'b1);
		post({!r, 8'h00});
	endtask
	task rbyte(input last);
		for (k = 7; k >= 0; k--) begin
			bitx(1'b1);
			v[k] = r;
		end
		bitx(last);
		post({1'b0, v});
	endtask
endmodule // lcr_bus_master

// ---- lcr_column_slave_test.sv ----
// lcr_column_slave_test.sv: self-checking bench for the column driver slave.
// assumes the bus master model and the checker are compiled first.
`timescale 1ns/1ps
module lcr_column_slave_test;
	localparam [5:0] AHI = 6'h2a; // arbitrary value
	localparam [7:0] AW = {AHI, 2'h2};
	localparam [7:0] AR = {AHI, 2'h3};
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg sync = 1'b0;
	reg addressSelectPin = 1'b1;
	reg [3:0] boardIdPins = 4'hf; // single device, own id
	wire scl, sdaOe, mOe, rxValid, systemType, cmdPhase;
	wire sdaWire = !(sdaOe || mOe);
	wire [8:0] rxWord;
	wire [39:0] colOut;
	wire [4:0] rowIndex;
	wire [1:0] muxRate, showState, topBank, accessOrder, bankPick;
	wire [5:0] xPointer;
	wire [3:0] subCounter;
	int errCount = 0;
	int samplesChecked = 0;
	int i;
	reg [7:0] d0, d1, md;
	reg [8:0] expQ[$];
	always #20 clk = !clk;
	lcr_column_slave #(.SLAVE_ADDR_HI(AHI)) u_lcr_column_slave (.clk, .reset_n, .scl,
		.sdaIn(sdaWire), .sdaOut(), .sdaOe, .sync, .addressSelectPin, .boardIdPins, .colOut,
		.rowIndex, .muxRate, .showState, .systemType, .topBank, .accessOrder, .bankPick,
		.xPointer, .subCounter, .cmdPhase);
	lcr_bus_master bm (.clk, .sdaWire, .scl, .sdaOe(mOe), .rxValid, .rxWord);
	task chk(input [23:0] g, input [23:0] e);
		samplesChecked++;
		if (g !== e) begin
			errCount++;
			$display("mismatch at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task wr(input [7:0] d, input a);
		expQ.push_back({a, 8'h00});
		bm.wbyte(d);
	endtask
	task rd(input last, input [7:0] d);
		expQ.push_back({1'b0, d});
		bm.rbyte(last);
	endtask
	task finishTest;
		$display("checks %0d, mismatches %0d", samplesChecked, errCount);
		if (errCount == 0 && samplesChecked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		if (rxValid === 1'b1) begin
			if (expQ.size() == 0) chk(rxWord, 24'hffffff);
			else chk(rxWord, expQ.pop_front());
		end
	end
	initial begin
		repeat (100000) @(posedge clk);
		errCount++;
		$display("mismatch at %0t: run timed out", $time);
		finishTest;
	end
	initial begin
		d0 = $urandom(32'h5a89_a358);
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (25000) @(posedge clk);
		md = $urandom;
		d0 = $urandom;
		d1 = $urandom;
		bm.start;
		wr(AW, 1);
		wr(8'hc0 | md[4:0], 1);
		wr(8'hfe, 1);
		wr(8'hef, 1);
		wr(8'hf1, 1);
		wr(8'h26, 1);
		chk({muxRate, showState, systemType, topBank, bankPick, xPointer, subCounter},
			{md[1:0], md[3:2], md[4], 2'h2, 2'h1, 6'h26, 4'hf});
		wr(d0, 1);
		wr(d1, 1);
		wr(d0 ^ d1, 0);
		bm.stop;
		chk({xPointer, subCounter}, {6'h01, 4'h0});
		bm.start;
		wr({AHI, 2'h0}, 0);
		wr(8'hc0, 0);
		bm.stop;
		$display("test write stream done");
		bm.start;
		wr(AW, 1);
		wr(8'hef, 1);
		wr(8'hf1, 1);
		wr(8'h26, 1);
		bm.start;
		wr(AR, 1);
		rd(0, d0);
		rd(1, d1);
		repeat (6) @(posedge clk);
		chk(sdaOe, 0);
		bm.stop;
		chk({xPointer, subCounter}, {6'h00, 4'h0});
		$display("test read back done");
		for (i = 0; i < 3; i++) begin
			bm.start;
			wr(AW, 1);
			wr(8'hef, 1);
			wr({4'hf, i[1:0], 2'h0}, 1);
			wr(8'h05, 1);
			wr(8'($urandom), 1);
			wr(8'($urandom), 1);
			bm.stop;
			chk({xPointer, bankPick}, i == 0 ? 8'h1c : i == 1 ? 8'h18 : 8'h16);
		end
		$display("test access orders done");
		bm.start;
		wr(AW, 1);
		wr(8'h49, 1);
		bm.stop;
		for (i = 1; i <= 8; i++) begin
			sync <= 1'b1;
			repeat (8) @(posedge clk);
			sync <= 1'b0;
			repeat (8) @(posedge clk);
			if (i == 3) chk(rowIndex, 3);
		end
		chk(rowIndex, 0);
		$display("test row scan done");
		bm.start;
		wr(AW, 1);
		wr(8'hfd, 1);
		wr(8'h45, 1);
		bm.stop;
		repeat (2) @(posedge clk);
		chk(colOut[39:38], {d1[0], d0[0]});
		$display("test display shading done");
		chk(24'(expQ.size()), 24'h00_0000);
		finishTest;
	end
endmodule // lcr_column_slave_test
